// ---- hw/timer_pulse_pkg.sv ----
/*
  Shared constants and types for the pulse-output timer: register offsets,
  field positions, reset values, encodings and the configuration carrier.
  Assumes a 32-bit APB slave with byte addresses and one register per word.
*/
package timer_pulse_pkg;

  // ----------------------------------------------------------------
  // bus geometry and register offsets
  // ----------------------------------------------------------------
  localparam int          ADDR_W                = 12;
  localparam int          DATA_W                = 32;
  localparam logic [11:0] RUN_CONTROL_OFFSET    = 12'h000;
  localparam logic [11:0] INTR_CONTROL_OFFSET   = 12'h004;
  localparam logic [11:0] PIN_ROUTING_OFFSET    = 12'h008;
  localparam logic [11:0] PRESCALER_OFFSET      = 12'h00C;
  localparam logic [11:0] MAIN_COUNTER_OFFSET   = 12'h010;
  localparam logic [11:0] IO_CONTROL_OFFSET     = 12'h014;
  localparam logic [11:0] MODE_OFFSET           = 12'h018;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int START_BIT          = 0;
  localparam int ACTIVE_BIT         = 1;
  localparam int LEVEL_LSB          = 0;
  localparam int REQUEST_BIT        = 3;
  localparam int TOGGLE_ROUTE_LSB   = 0;
  localparam int INVERSE_ROUTE_LSB  = 3;
  localparam int POLARITY_BIT       = 0;
  localparam int INV_ENABLE_BIT     = 2;
  localparam int MODE_LSB           = 0;
  localparam int SOURCE_LSB         = 4;

  // ----------------------------------------------------------------
  // encodings, reset values and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_PULSE          = 3'h1;
  localparam logic [2:0] SOURCE_DIV8         = 3'h1;
  localparam logic [2:0] LEVEL_DISABLED      = 3'h0;
  localparam logic [1:0] TOGGLE_ROUTE_P1_7   = 2'h1;
  localparam logic [1:0] INVERSE_ROUTE_P3_7  = 2'h0;
  localparam logic [7:0] PRESCALER_RESET     = 8'hFF;
  localparam logic [7:0] MAIN_COUNTER_RESET  = 8'hFF;
  localparam int         COUNTER_W           = 8;
  localparam int         DIV8_RATIO          = 8;
  localparam int         PCLK_HZ             = 10_000_000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    REG_RUN, REG_INTR, REG_ROUTE, REG_PRESCALER, REG_MAIN, REG_IO, REG_MODE, REG_NONE
  } reg_index_type;

  typedef enum logic {STOPPED, RUNNING} run_state_type;

  typedef struct packed {
    logic       start;
    logic [2:0] level;
    logic       request;
    logic [1:0] toggle_route;
    logic [1:0] inverse_route;
    logic       polarity;
    logic       inv_enable;
    logic [2:0] mode;
    logic [2:0] source;
  } timer_cfg_type;

endpackage

// ---- hw/count_source_divider.sv ----
/*
  Divide-by-N enable generator producing the count source tick.
  Assumes it shares pclk with its user; dropping enable restarts the division.
*/
module count_source_divider #(
  parameter int RATIO = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  output logic      tick
);

  localparam int CW = $clog2(RATIO);
  localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

  logic [CW-1:0] phase_q;
  logic [CW-1:0] phase_d;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // held at zero while stopped so every start sees a full first period
  always_comb begin
    phase_d = phase_q;
    if (!enable) begin
      phase_d = '0;
    end else if (phase_q == LAST) begin
      phase_d = '0;
    end else begin
      phase_d = phase_q + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign tick = enable && (phase_q == LAST);

endmodule // count_source_divider

// ---- hw/reload_down_counter.sv ----
/*
  Down-counter with a reload register, used for prescaler and main counter.
  Assumes tick is a one-cycle enable on pclk; a write sets both values.
*/
module reload_down_counter #(
  parameter int               WIDTH     = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             tick,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_value,
  output logic      [WIDTH-1:0] count,
  output logic                  underflow
);

  logic [WIDTH-1:0] reload_q;
  logic [WIDTH-1:0] reload_d;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // ----------------------------------------------------------------
  // count and reload
  // ----------------------------------------------------------------
  always_comb begin
    reload_d = reload_q;
    count_d  = count_q;
    if (wr_en) begin
      reload_d = wr_value;
      count_d  = wr_value;
    end else if (tick) begin
      if (count_q == '0) begin
        count_d = reload_q; // RQ13
      end else begin
        count_d = count_q - WIDTH'(1); // RQ1
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= RESET_VAL;
      count_q  <= RESET_VAL;
    end else begin
      reload_q <= reload_d;
      count_q  <= count_d;
    end
  end

  // a write in the same cycle wins and suppresses the underflow
  assign underflow = tick && !wr_en && (count_q == '0);
  assign count     = count_q;

endmodule // reload_down_counter

// ---- hw/timer_pulse_output.sv ----
/*
  Pulse-output timer: APB register slave, run control, divide-by-8 count
  source, 8-bit prescaler and 8-bit main counter, toggling output pins.
  Assumes a single pclk domain and an APB master that follows the protocol.
*/
// Summary of operation
// RQ1: prescaler counts div8_clock ticks; main counter steps on each prescaler underflow.
// RQ2: in pulse mode each main underflow inverts toggle and inverted outputs.
// RQ3: toggle interval is source period times (prescaler+1) times (counter+1).
// RQ4: software loads 249 and 9 for 1 ms from a 20 MHz clock.
// RQ5: count start bit 0 starts on 1, stops on 0, reads back.
// RQ6: read-only count active flag at bit 1 shows counting in progress.
// RQ7: software polls the active flag after stopping before reconfiguring.
// RQ8: software stops, disables interrupt, routes pins, then writes counts.
// RQ9: three-bit priority level in bits 2..0; zero disables the interrupt.
// RQ10: request flag at bit 3 reads 0 when idle, software writes clear it.
// RQ11: toggle pin route in bits 1..0; value 01 selects port 1 bit 7.
// RQ12: inverse pin route in bits 4..3; value 00 selects port 3 bit 7.
// RQ13: both counters reload from written values and keep counting while started.
// RQ14: operating mode field value 001 selects pulse output mode.
// RQ15: clock source field bits 6..4 value 001 selects the divide-by-8 clock.
// RQ16: with polarity select 0 the toggle output starts high when counting begins.
// RQ17: with inverted output enable 1 the second pin drives the inverse.
module timer_pulse_output #(
  parameter int DIV_RATIO = timer_pulse_pkg::DIV8_RATIO
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             toggle_output_pin,
  output logic             inverted_output_pin,
  output logic             port1_7_out,
  output logic             port1_7_oe,
  output logic             port3_7_out,
  output logic             port3_7_oe
);

  // ----------------------------------------------------------------
  // address decoding
  // ----------------------------------------------------------------
  function automatic timer_pulse_pkg::reg_index_type decode_addr(input logic [11:0] addr);
    if (addr == timer_pulse_pkg::RUN_CONTROL_OFFSET) begin
      decode_addr = timer_pulse_pkg::REG_RUN;
    end else if (addr == timer_pulse_pkg::INTR_CONTROL_OFFSET) begin
      decode_addr = timer_pulse_pkg::REG_INTR;
    end else if (addr == timer_pulse_pkg::PIN_ROUTING_OFFSET) begin
      decode_addr = timer_pulse_pkg::REG_ROUTE;
    end else if (addr == timer_pulse_pkg::PRESCALER_OFFSET) begin
      decode_addr = timer_pulse_pkg::REG_PRESCALER;
    end else if (addr == timer_pulse_pkg::MAIN_COUNTER_OFFSET) begin
      decode_addr = timer_pulse_pkg::REG_MAIN;
    end else if (addr == timer_pulse_pkg::IO_CONTROL_OFFSET) begin
      decode_addr = timer_pulse_pkg::REG_IO;
    end else if (addr == timer_pulse_pkg::MODE_OFFSET) begin
      decode_addr = timer_pulse_pkg::REG_MODE;
    end else begin
      decode_addr = timer_pulse_pkg::REG_NONE;
    end
  endfunction

  timer_pulse_pkg::reg_index_type sel_index;
  logic                           access;
  logic                           wr_strobe;
  logic                           wr_lane0;

  assign sel_index = decode_addr(paddr);
  assign access    = psel && penable;
  assign wr_strobe = access && pwrite && (sel_index != timer_pulse_pkg::REG_NONE);
  // every register lives in byte lane 0; other lanes have nothing to store
  assign wr_lane0  = wr_strobe && pstrb[0];

  // the slave never stalls; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && (sel_index == timer_pulse_pkg::REG_NONE);

  // ----------------------------------------------------------------
  // counter chain
  // ----------------------------------------------------------------
  timer_pulse_pkg::timer_cfg_type cfg_q;
  timer_pulse_pkg::timer_cfg_type cfg_d;
  timer_pulse_pkg::run_state_type state_q;
  timer_pulse_pkg::run_state_type state_d;

  logic       counting;
  logic       source_tick;
  logic       pre_underflow;
  logic       main_underflow;
  logic [7:0] pre_count;
  logic [7:0] main_count;
  logic       pre_write;
  logic       main_write;

  assign counting   = (state_q == timer_pulse_pkg::RUNNING);
  assign pre_write  = wr_lane0 && (sel_index == timer_pulse_pkg::REG_PRESCALER);
  assign main_write = wr_lane0 && (sel_index == timer_pulse_pkg::REG_MAIN);

  count_source_divider #(
    .RATIO (DIV_RATIO)
  ) u_divider (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (counting), // RQ15
    .tick    (source_tick)
  );

  reload_down_counter #(
    .WIDTH     (timer_pulse_pkg::COUNTER_W),
    .RESET_VAL (timer_pulse_pkg::PRESCALER_RESET)
  ) u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (source_tick), // RQ1
    .wr_en     (pre_write),
    .wr_value  (pwdata[7:0]),
    .count     (pre_count),
    .underflow (pre_underflow)
  );

  // the main counter steps once per full prescaler cycle, giving the product period
  reload_down_counter #(
    .WIDTH     (timer_pulse_pkg::COUNTER_W),
    .RESET_VAL (timer_pulse_pkg::MAIN_COUNTER_RESET)
  ) u_main_counter (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (pre_underflow), // RQ1 RQ3
    .wr_en     (main_write),
    .wr_value  (pwdata[7:0]),
    .count     (main_count),
    .underflow (main_underflow)
  );

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    if (wr_lane0) begin
      if (sel_index == timer_pulse_pkg::REG_RUN) begin
        cfg_d.start = pwdata[timer_pulse_pkg::START_BIT]; // RQ5
      end else if (sel_index == timer_pulse_pkg::REG_INTR) begin
        cfg_d.level = pwdata[timer_pulse_pkg::LEVEL_LSB +: 3]; // RQ9
        // writing 0 clears; writing 1 cannot raise a request by itself
        cfg_d.request = cfg_q.request && pwdata[timer_pulse_pkg::REQUEST_BIT]; // RQ10
      end else if (sel_index == timer_pulse_pkg::REG_ROUTE) begin
        cfg_d.toggle_route  = pwdata[timer_pulse_pkg::TOGGLE_ROUTE_LSB +: 2]; // RQ11
        cfg_d.inverse_route = pwdata[timer_pulse_pkg::INVERSE_ROUTE_LSB +: 2]; // RQ12
      end else if (sel_index == timer_pulse_pkg::REG_IO) begin
        cfg_d.polarity   = pwdata[timer_pulse_pkg::POLARITY_BIT];
        cfg_d.inv_enable = pwdata[timer_pulse_pkg::INV_ENABLE_BIT];
      end else if (sel_index == timer_pulse_pkg::REG_MODE) begin
        cfg_d.mode   = pwdata[timer_pulse_pkg::MODE_LSB +: 3];
        cfg_d.source = pwdata[timer_pulse_pkg::SOURCE_LSB +: 3];
      end
    end
    // a request raised in the clearing cycle survives the clear
    if (main_underflow) begin
      cfg_d.request = 1'b1; // RQ10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // run control and output level
  // ----------------------------------------------------------------
  logic mode_ok;
  logic level_q;
  logic level_d;
  logic inv_level_q;
  logic inv_level_d;

  // only pulse mode fed from the divide-by-8 source is built here
  assign mode_ok = (cfg_q.mode == timer_pulse_pkg::MODE_PULSE) // RQ14
                && (cfg_q.source == timer_pulse_pkg::SOURCE_DIV8); // RQ15

  always_comb begin
    state_d = state_q;
    level_d = level_q;
    case (state_q)
      timer_pulse_pkg::STOPPED: begin
        if (cfg_q.start && mode_ok) begin
          state_d = timer_pulse_pkg::RUNNING; // RQ5
          level_d = !cfg_q.polarity; // RQ16
        end
      end
      timer_pulse_pkg::RUNNING: begin
        if (!cfg_q.start || !mode_ok) begin
          state_d = timer_pulse_pkg::STOPPED; // RQ5
        end else if (main_underflow) begin
          level_d = !level_q; // RQ2
        end
      end
      default: begin
        state_d = timer_pulse_pkg::STOPPED;
      end
    endcase
    inv_level_d = !level_d; // RQ17
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= timer_pulse_pkg::STOPPED;
      level_q     <= 1'b0;
      inv_level_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      level_q     <= level_d;
      inv_level_q <= inv_level_d;
    end
  end

  // ----------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------
  logic toggle_routed;
  logic inverse_routed;

  assign toggle_routed  = (cfg_q.toggle_route == timer_pulse_pkg::TOGGLE_ROUTE_P1_7); // RQ11
  assign inverse_routed = (cfg_q.inverse_route == timer_pulse_pkg::INVERSE_ROUTE_P3_7) // RQ12
                       && cfg_q.inv_enable; // RQ17

  assign toggle_output_pin   = level_q; // RQ2
  assign inverted_output_pin = cfg_q.inv_enable && inv_level_q; // RQ2 RQ17
  assign port1_7_out         = toggle_routed && level_q;
  assign port1_7_oe          = toggle_routed && (cfg_q.mode == timer_pulse_pkg::MODE_PULSE);
  assign port3_7_out         = inverse_routed && inv_level_q;
  assign port3_7_oe          = inverse_routed && (cfg_q.mode == timer_pulse_pkg::MODE_PULSE);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // captured in the setup cycle so the access phase shows registered data
  always_comb begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite) begin
      prdata_d = '0;
      if (sel_index == timer_pulse_pkg::REG_RUN) begin
        prdata_d[timer_pulse_pkg::START_BIT]  = cfg_q.start; // RQ5
        prdata_d[timer_pulse_pkg::ACTIVE_BIT] = counting; // RQ6
      end else if (sel_index == timer_pulse_pkg::REG_INTR) begin
        prdata_d[timer_pulse_pkg::LEVEL_LSB +: 3] = cfg_q.level; // RQ9
        prdata_d[timer_pulse_pkg::REQUEST_BIT]    = cfg_q.request; // RQ10
      end else if (sel_index == timer_pulse_pkg::REG_ROUTE) begin
        prdata_d[timer_pulse_pkg::TOGGLE_ROUTE_LSB +: 2]  = cfg_q.toggle_route;
        prdata_d[timer_pulse_pkg::INVERSE_ROUTE_LSB +: 2] = cfg_q.inverse_route;
      end else if (sel_index == timer_pulse_pkg::REG_PRESCALER) begin
        prdata_d[7:0] = pre_count;
      end else if (sel_index == timer_pulse_pkg::REG_MAIN) begin
        prdata_d[7:0] = main_count;
      end else if (sel_index == timer_pulse_pkg::REG_IO) begin
        prdata_d[timer_pulse_pkg::POLARITY_BIT]   = cfg_q.polarity;
        prdata_d[timer_pulse_pkg::INV_ENABLE_BIT] = cfg_q.inv_enable;
      end else if (sel_index == timer_pulse_pkg::REG_MODE) begin
        prdata_d[timer_pulse_pkg::MODE_LSB +: 3]   = cfg_q.mode;
        prdata_d[timer_pulse_pkg::SOURCE_LSB +: 3] = cfg_q.source;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

endmodule // timer_pulse_output

// ---- hw/placeholder_unused.sv ----
/*
  Intentionally empty compilation unit.
  Assumes nothing.
*/

// ---- test/timer_pulse_output_asserts.sv ----
/*
  Port-level checker for the pulse-output timer, bound into its top module.
  Assumes one pclk domain, presetn async low, register map of the package.
*/
module timer_pulse_output_asserts #(
  parameter int DIV_RATIO = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        toggle_output_pin,
  input wire logic        inverted_output_pin,
  input wire logic        port1_7_out,
  input wire logic        port1_7_oe,
  input wire logic        port3_7_out,
  input wire logic        port3_7_oe
);
  // ----------------------------------------------------------------
  // shadow of the start bit and spacing of output changes
  // ----------------------------------------------------------------
  logic        wr_run;
  logic        mapped;
  logic        start_q, start_d, level_q;
  logic [15:0] gap_q, gap_d;
  assign wr_run = psel && penable && pwrite && pstrb[0]
                  && (paddr == timer_pulse_pkg::RUN_CONTROL_OFFSET);
  assign mapped = paddr inside {timer_pulse_pkg::RUN_CONTROL_OFFSET,
    timer_pulse_pkg::INTR_CONTROL_OFFSET, timer_pulse_pkg::PIN_ROUTING_OFFSET,
    timer_pulse_pkg::PRESCALER_OFFSET, timer_pulse_pkg::MAIN_COUNTER_OFFSET,
    timer_pulse_pkg::IO_CONTROL_OFFSET, timer_pulse_pkg::MODE_OFFSET};
  always_comb begin
    start_d = wr_run ? pwdata[0] : start_q;
    gap_d   = (toggle_output_pin != level_q) ? 16'h0 : gap_q + {15'h0, gap_q != 16'hFFFF};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      level_q <= 1'b0;
      gap_q   <= 16'h0;
    end else begin
      start_q <= start_d;
      level_q <= toggle_output_pin;
      gap_q   <= gap_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pready_high_a: assert property (pready) else $error("pready low");
  err_unmapped_a: assert property ((psel && penable) |-> (pslverr == !mapped))
    else $error("pslverr does not match address map");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  read_zero_a: assert property ((psel && penable && !pwrite && !mapped) |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  read_upper_a: assert property ((psel && penable && !pwrite) |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  toggle_run_a: assert property ($changed(toggle_output_pin) |-> (start_q || $past(start_q, 2)))
    else $error("output changed while stopped");
  // a start edge may move the level at once, so only steady changes are spaced
  toggle_gap_a: assert property (($changed(toggle_output_pin) && $past(start_q, 3))
    |-> gap_q >= DIV_RATIO - 1) else $error("output changes too close");
  inverse_pair_a: assert property (inverted_output_pin |-> !toggle_output_pin)
    else $error("inverted output equals pulse output");
  p1_route_a: assert property (port1_7_oe |-> port1_7_out == toggle_output_pin)
    else $error("port1_7 not carrying pulse output");
  p3_route_a: assert property (port3_7_oe |-> port3_7_out == !toggle_output_pin)
    else $error("port3_7 not carrying inverse");
endmodule // timer_pulse_output_asserts

bind timer_pulse_output timer_pulse_output_asserts #(.DIV_RATIO(DIV_RATIO)) u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .toggle_output_pin(toggle_output_pin),
  .inverted_output_pin(inverted_output_pin), .port1_7_out(port1_7_out),
  .port1_7_oe(port1_7_oe), .port3_7_out(port3_7_out), .port3_7_oe(port3_7_oe));

// ---- test/tb_timer_pulse_output.sv ----
/*
  Self-checking bench for the pulse-output timer, driven over APB.
  Assumes pready answers in bounded time and a 10 MHz pclk.
*/
module tb_timer_pulse_output;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          DIV  = 8;
  localparam logic [11:0] RUN  = timer_pulse_pkg::RUN_CONTROL_OFFSET;
  localparam logic [11:0] INTR = timer_pulse_pkg::INTR_CONTROL_OFFSET;
  localparam logic [11:0] ROUT = timer_pulse_pkg::PIN_ROUTING_OFFSET;
  localparam logic [11:0] PRE  = timer_pulse_pkg::PRESCALER_OFFSET;
  localparam logic [11:0] MAIN = timer_pulse_pkg::MAIN_COUNTER_OFFSET;
  localparam logic [11:0] IOC  = timer_pulse_pkg::IO_CONTROL_OFFSET;
  localparam logic [11:0] MODE = timer_pulse_pkg::MODE_OFFSET;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        tog, inv, p1_out, p1_oe, p3_out, p3_oe, err, lvl;
  int          fail_count, checks_done, n;
  logic [11:0] offs [7] = '{RUN, INTR, ROUT, PRE, MAIN, IOC, MODE};
  logic [31:0] rstv [7] = '{32'h0, 32'h0, 32'h0, 32'hFF, 32'hFF, 32'h0, 32'h0};
  logic [7:0]  pv [4] = '{8'h02, 8'h00, 8'h03, 8'h00};
  logic [7:0]  mv [4] = '{8'h02, 8'h03, 8'h00, 8'h00};
  logic [7:0]  bad [4] = '{8'h12, 8'h21, 8'h10, 8'h01};

  timer_pulse_output #(.DIV_RATIO(DIV)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .toggle_output_pin(tog), .inverted_output_pin(inv),
    .port1_7_out(p1_out), .port1_7_oe(p1_oe), .port3_7_out(p3_out), .port3_7_oe(p3_oe));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // master holds the request until pready is sampled high at a rising edge, giving up after 16 edges
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    r = prdata;
    e = pslverr;
    check("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
    check("write error", 32'h0, {31'h0, err});
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    check(what, exp, rd);
  endtask

  task automatic poll_active(input logic exp);
    int k;
    k = 0;
    do begin
      apb(1'b0, RUN, 32'h0, rd, err);
      k++;
    end while (rd[1] !== exp && k < 20);
    check("count active flag", {31'h0, exp}, {31'h0, rd[1]});
  endtask

  // stop first, wait for the flag, then interrupt, pins, counts, mode, start
  task automatic configure(input logic [7:0] p, input logic [7:0] m, input logic [7:0] io,
                           input logic [7:0] md);
    wr(RUN, 32'h0);
    poll_active(1'b0);
    wr(INTR, 32'h0);
    wr(ROUT, 32'h01);
    wr(PRE, {24'h0, p});
    wr(MAIN, {24'h0, m});
    wr(IOC, {24'h0, io});
    wr(MODE, {24'h0, md});
    wr(RUN, 32'h1);
  endtask

  // cycles between two successive changes of the pulse output
  task automatic gap(output int c);
    logic prev;
    int   w;
    w = 0;
    @(negedge pclk);
    prev = tog;
    while (tog === prev && w < 5000) begin
      @(negedge pclk);
      w++;
    end
    prev = tog;
    c = 0;
    while (tog === prev && c < 5000) begin
      @(negedge pclk);
      c++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    tally_and_finish;
  end

  initial begin
    fail_count = 0; checks_done = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hF;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd_chk("reset value", offs[i], rstv[i]);
    check("pins after reset", 32'h0, {26'h0, tog, inv, p1_out, p1_oe, p3_out, p3_oe});
    $display("test reset values done");

    apb(1'b0, 12'h01C, 32'h0, rd, err);
    check("unmapped read error", 32'h1, {31'h0, err});
    check("unmapped read data", 32'h0, rd);
    apb(1'b1, 12'h01C, 32'hFF, rd, err);
    check("unmapped write error", 32'h1, {31'h0, err});
    $display("test unmapped access done");

    wr(INTR, 32'h0D); rd_chk("interrupt control", INTR, 32'h05);
    wr(ROUT, 32'h1B); rd_chk("pin routing", ROUT, 32'h1B);
    wr(RUN, 32'h02); rd_chk("active flag read only", RUN, 32'h0);
    wr(PRE, 32'hF9); rd_chk("prescaler", PRE, 32'hF9);
    pstrb <= 4'hE;
    wr(PRE, 32'h55);
    pstrb <= 4'hF;
    rd_chk("masked write ignored", PRE, 32'hF9);
    wr(MAIN, 32'h09); rd_chk("main counter", MAIN, 32'h09);
    $display("test register access done");

    configure(8'h01, 8'h01, 8'h04, 8'h11);
    poll_active(1'b1);
    check("pulse start level", 32'h1, {31'h0, tog});
    check("inverted level", 32'h0, {31'h0, inv});
    check("port enables", 32'h3, {30'h0, p1_oe, p3_oe});
    check("port levels", {30'h0, tog, !tog}, {30'h0, p1_out, p3_out});
    rd_chk("io control", IOC, 32'h04);
    rd_chk("mode", MODE, 32'h11);
    for (int i = 0; i < 3; i++) begin
      gap(n);
      check("toggle interval", DIV * 4, n);
    end
    rd_chk("request set by underflow", INTR, 32'h08);
    gap(n);
    wr(INTR, 32'h0); rd_chk("request cleared", INTR, 32'h0);
    $display("test pulse output done");

    for (int i = 0; i < 4; i++) begin
      configure(pv[i], mv[i], {7'h02, i[0]}, 8'h11);
      poll_active(1'b1);
      check("start level by polarity", {31'h0, !i[0]}, {31'h0, tog});
      check("inverse output", {31'h0, i[0]}, {31'h0, inv});
      gap(n);
      check("toggle interval", DIV * (pv[i] + 1) * (mv[i] + 1), n);
    end
    $display("test count values done");

    wr(RUN, 32'h0);
    poll_active(1'b0);
    lvl = tog;
    repeat (100) @(negedge pclk);
    check("level held when stopped", {31'h0, lvl}, {31'h0, tog});
    $display("test stop done");

    for (int i = 0; i < 4; i++) begin
      configure(8'h00, 8'h00, 8'h04, bad[i]);
      repeat (10) @(posedge pclk);
      rd_chk("other mode or source idle", RUN, 32'h01);
      check("level held", {31'h0, lvl}, {31'h0, tog});
    end
    wr(RUN, 32'h0);
    $display("test mode and source done");
    tally_and_finish;
  end
endmodule // tb_timer_pulse_output
